//--- core/scrb_config_bank.sv
// Purpose: Configuration register bank of a pressure and temperature sensor
// Assumes: Register port and event inputs come from sys_clk logic
// Notes:   Event inputs are single-cycle pulses
// Contract
// R1 - Low three bits of fifo_config_second keep one of every 2^n samples.
// R2 - Source code 1 picks filtered samples; every other code picks unfiltered.
// R3 - interrupt_control bit 0 picks push-pull or open-drain pin drive.
// R4 - interrupt_control bit 1 picks low or high asserted pin level.
// R5 - interrupt_control bit 2 latches interrupts on pin and in flags.
// R6 - interrupt_control bit 3 enables the FIFO threshold interrupt.
// R7 - interrupt_control bit 4 enables the FIFO full interrupt.
// R8 - interrupt_control bit 6 enables the sample ready interrupt.
// R9 - serial_interface_setup bit 0 selects three-wire serial, else four-wire.
// R10 - serial_interface_setup bit 1 enables bus watchdog, preset from nonvolatile memory.
// R11 - serial_interface_setup bit 2 picks a 1.25 ms or 40 ms timeout.
// R12 - power_control bit 0 enables pressure measurement.
// R13 - power_control bit 1 enables temperature measurement.
// R14 - Mode 00 sleeps, 01 and 10 force one measurement, 11 runs continuously.
// R15 - Pressure and temperature oversampling codes 000 to 101 give x1 to x32.
// R16 - Rate exponent accepts 0 to 17; larger writes become 17.
// R17 - Measurement period is 5 ms times two to the exponent.
// R18 - Smoothing code 000 bypasses; others give coefficient 2^code minus one.
// R19 - Undefined bits read zero and ignore writes.
`timescale 1ns/1ps
`include "scrb_params.svh"
module scrb_config_bank
  import scrb_pkg::*;
#(
  parameter int BASE_CYCLES      = `SCRB_BASE_PERIOD_NS / `SCRB_CLK_PERIOD_NS,
  parameter int WDT_SHORT_CYCLES = `SCRB_WDT_SHORT_NS / `SCRB_CLK_PERIOD_NS,
  parameter int WDT_LONG_CYCLES  = `SCRB_WDT_LONG_NS / `SCRB_CLK_PERIOD_NS
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clkEn,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regWrData,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  output logic            regHit,
  input  wire logic       fifoWatermarkEvt,
  input  wire logic       fifoFullEvt,
  input  wire logic       dataReadyEvt,
  input  wire logic [2:0] intFlagsClr,
  output logic      [2:0] intFlags,
  output logic            irqPinOut,
  output logic            irqPinOe,
  output logic      [2:0] fifoDecimation,
  output logic            fifoFiltered,
  output logic            fifoSampleTake,
  output logic            threeWireSerial,
  input  wire logic       nvmWdtEn,
  input  wire logic       nvmWdtSel,
  input  wire logic       i2cBusy,
  input  wire logic       i2cActivity,
  output logic            wdtTimeout,
  output logic            pressEnable,
  output logic            tempEnable,
  output scrb_mode_e      powerMode,
  input  wire logic       measDone,
  output logic            measStart,
  output logic      [2:0] pressOversample,
  output logic      [2:0] thermalOversample,
  output logic      [4:0] odrExponent,
  output logic            iirBypass,
  output logic      [6:0] iirCoef
);
  localparam int WDT_W = 32;
  localparam int ODR_W = 17;

  if (BASE_CYCLES < 2 || WDT_SHORT_CYCLES < 2 || WDT_LONG_CYCLES < WDT_SHORT_CYCLES)
  begin : g_bad_counts
    $error("scrb_config_bank: unusable timing counts");
  end

  typedef struct packed {
    logic [7:0]       fifo2;
    logic [7:0]       intCtl;
    logic [7:0]       ifSetup;
    logic [7:0]       pwrCtl;
    logic [7:0]       osr;
    logic [7:0]       odr;
    logic [7:0]       iir;
    logic [7:0]       rdData;
    logic [2:0]       flags;
    logic [6:0]       sampleCnt;
    logic             sampleTake;
    logic [ODR_W-1:0] odrCnt;
    logic             measStart;
  } scrb_bank_s;

  scrb_bank_s st_q, st_d;

  logic             baseTick;
  logic             wdtExpire;
  logic             odrWrite;
  logic [2:0]       evtVec;
  logic [2:0]       evtEn;
  logic             latchOn;
  logic [6:0]       decimMask;
  logic [ODR_W-1:0] periodMask;
  logic [WDT_W-1:0] wdtLimit;
  logic [7:0]       wrMasked;
  logic [7:0]       rdMux;

  assign evtVec = {dataReadyEvt, fifoFullEvt, fifoWatermarkEvt};
  assign evtEn = {st_q.intCtl[6], st_q.intCtl[4], st_q.intCtl[3]};   // [R6] [R7] [R8]
  assign latchOn = st_q.intCtl[2];
  assign odrWrite = regWrEn && regAddr == `SCRB_OFS_ODR;
  assign decimMask = 7'((8'h01 << st_q.fifo2[2:0]) - 8'h01);
  assign periodMask = ODR_W'((18'h00001 << st_q.odr[4:0]) - 18'h00001);
  assign wdtLimit = st_q.ifSetup[2] ? WDT_W'(WDT_LONG_CYCLES)
                                    : WDT_W'(WDT_SHORT_CYCLES);  // [R11]

  always_comb begin
    case (regAddr)
      `SCRB_OFS_FIFO2:   wrMasked = regWrData & `SCRB_MASK_FIFO2;
      `SCRB_OFS_INTCTL:  wrMasked = regWrData & `SCRB_MASK_INTCTL;
      `SCRB_OFS_IFSETUP: wrMasked = regWrData & `SCRB_MASK_IFSETUP;
      `SCRB_OFS_PWRCTL:  wrMasked = regWrData & `SCRB_MASK_PWRCTL;
      `SCRB_OFS_OSR:     wrMasked = regWrData & `SCRB_MASK_OSR;
      `SCRB_OFS_IIR:     wrMasked = regWrData & `SCRB_MASK_IIR;
      default:           wrMasked = regWrData & `SCRB_MASK_ODR;    // [R19]
    endcase
  end

  always_comb begin
    regHit = 1'b1;
    case (regAddr)
      `SCRB_OFS_FIFO2:   rdMux = st_q.fifo2;
      `SCRB_OFS_INTCTL:  rdMux = st_q.intCtl;
      `SCRB_OFS_IFSETUP: rdMux = st_q.ifSetup;
      `SCRB_OFS_PWRCTL:  rdMux = st_q.pwrCtl;
      `SCRB_OFS_OSR:     rdMux = st_q.osr;
      `SCRB_OFS_ODR:     rdMux = st_q.odr;
      `SCRB_OFS_IIR:     rdMux = st_q.iir;
      default: begin
        rdMux = `SCRB_RESET_BYTE;                                   // [R19]
        regHit = 1'b0;
      end
    endcase
  end

  always_comb begin
    st_d = st_q;
    st_d.measStart = 1'b0;
    st_d.sampleTake = 1'b0;
    if (rst) begin
      st_d = '0;
      st_d.ifSetup[1] = nvmWdtEn;                                    // [R10]
      st_d.ifSetup[2] = nvmWdtSel;                                   // [R11]
    end else begin
      if (regRdEn) begin
        st_d.rdData = rdMux;
      end
      if (latchOn) begin
        st_d.flags = (st_q.flags & ~intFlagsClr) | (evtVec & evtEn); // [R5]
      end else begin
        st_d.flags = evtVec & evtEn;                                 // [R5]
      end
      if (dataReadyEvt) begin
        st_d.sampleCnt = st_q.sampleCnt + 7'h01;
        st_d.sampleTake = (st_q.sampleCnt & decimMask) == 7'h00;     // [R1]
      end
      if (baseTick) begin
        st_d.odrCnt = st_q.odrCnt + ODR_W'(1);
        if (scrb_decode_mode(st_q.pwrCtl[5:4]) == SCRB_NORMAL
            && (st_q.odrCnt & periodMask) == '0) begin
          st_d.measStart = 1'b1;                                     // [R14] [R17]
        end
      end
      if (measDone && scrb_decode_mode(st_q.pwrCtl[5:4]) == SCRB_FORCED) begin
        st_d.pwrCtl[5:4] = 2'h0;                                     // [R14]
      end
      if (regWrEn) begin
        case (regAddr)
          `SCRB_OFS_FIFO2: begin
            st_d.fifo2 = wrMasked;                                   // [R1] [R2]
            st_d.sampleCnt = 7'h00;
          end
          `SCRB_OFS_INTCTL:  st_d.intCtl = wrMasked;                 // [R3] [R4]
          `SCRB_OFS_IFSETUP: st_d.ifSetup = wrMasked;                // [R9] [R10]
          `SCRB_OFS_PWRCTL: begin
            st_d.pwrCtl = wrMasked;                                  // [R12] [R13]
            if (scrb_decode_mode(wrMasked[5:4]) == SCRB_FORCED) begin
              st_d.measStart = 1'b1;                                 // [R14]
            end
          end
          `SCRB_OFS_OSR: st_d.osr = wrMasked;                        // [R15]
          `SCRB_OFS_ODR: begin
            st_d.odrCnt = '0;
            if (wrMasked[4:0] > `SCRB_ODR_MAX) begin
              st_d.odr = {3'h0, `SCRB_ODR_MAX};                      // [R16]
            end else begin
              st_d.odr = wrMasked;
            end
          end
          `SCRB_OFS_IIR: st_d.iir = wrMasked;                        // [R18]
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || clkEn) begin
      st_q <= st_d;
    end
  end

  scrb_interval_timer #(
    .WIDTH (WDT_W)
  ) u_base_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .run     (1'b1),
    .restart (odrWrite),
    .limit   (WDT_W'(BASE_CYCLES)),
    .expire  (baseTick)
  );

  scrb_interval_timer #(
    .WIDTH (WDT_W)
  ) u_wdt_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .run     (st_q.ifSetup[1] && i2cBusy),                           // [R10]
    .restart (i2cActivity),
    .limit   (wdtLimit),
    .expire  (wdtExpire)
  );

  scrb_irq_pin u_irq_pin (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .clkEn      (clkEn),
    .irqActive  (|st_q.flags),
    .activeHigh (st_q.intCtl[1]),
    .openDrain  (st_q.intCtl[0]),
    .irqPinOut  (irqPinOut),
    .irqPinOe   (irqPinOe)
  );

  assign regRdData = st_q.rdData;
  assign intFlags = st_q.flags;
  assign fifoDecimation = st_q.fifo2[2:0];
  assign fifoFiltered = st_q.fifo2[4:3] == 2'h1;                     // [R2]
  assign fifoSampleTake = st_q.sampleTake;
  assign threeWireSerial = st_q.ifSetup[0];                          // [R9]
  assign wdtTimeout = wdtExpire;
  assign pressEnable = st_q.pwrCtl[0];                               // [R12]
  assign tempEnable = st_q.pwrCtl[1];                                // [R13]
  assign powerMode = scrb_decode_mode(st_q.pwrCtl[5:4]);             // [R14]
  assign measStart = st_q.measStart;
  assign pressOversample = st_q.osr[2:0];                            // [R15]
  assign thermalOversample = st_q.osr[5:3];                          // [R15]
  assign odrExponent = st_q.odr[4:0];
  assign iirBypass = st_q.iir[3:1] == 3'h0;                          // [R18]
  assign iirCoef = 7'((8'h01 << st_q.iir[3:1]) - 8'h01);             // [R18]

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_wr(logic [7:0] ofs);
    clkEn && regWrEn && regAddr == ofs;
  endsequence

  a_fifo_decim: assert property (s_wr(`SCRB_OFS_FIFO2) |=> // [R1]
      fifoDecimation == $past(regWrData[2:0])) else $error("decimation not stored");

  a_take_first: assert property (s_wr(`SCRB_OFS_FIFO2) ##1 !dataReadyEvt // [R1]
      ##1 clkEn && dataReadyEvt |=> fifoSampleTake) else $error("first sample lost");

  a_data_source: assert property (s_wr(`SCRB_OFS_FIFO2) |=> // [R2]
      fifoFiltered == ($past(regWrData[4:3]) == 2'h1)) else $error("bad source");

  a_intctl_store: assert property (s_wr(`SCRB_OFS_INTCTL) |=> // [R3] [R19]
      st_q.intCtl == ($past(regWrData) & `SCRB_MASK_INTCTL))
    else $error("control not stored");

  a_latch_hold: assert property (clkEn && latchOn && intFlags[0] && !intFlagsClr[0] // [R5]
      |=> intFlags[0]) else $error("latched flag lost");

  a_set_wins: assert property (clkEn && latchOn && dataReadyEvt && evtEn[2] // [R5]
      && intFlagsClr[2] |=> intFlags[2]) else $error("clear beat event");

  a_unlatched_drop: assert property (clkEn && !latchOn && (evtVec & evtEn) == 3'h0 // [R5]
      |=> intFlags == 3'h0) else $error("unlatched flag stuck");

  a_wm_enable: assert property (clkEn && fifoWatermarkEvt && evtEn[0] |=> intFlags[0]) // [R6]
    else $error("threshold event lost");

  a_full_gate: assert property (clkEn && !evtEn[1] && !intFlags[1] |=> !intFlags[1]) // [R7]
    else $error("disabled full flag set");

  a_drdy_enable: assert property (clkEn && dataReadyEvt && evtEn[2] |=> intFlags[2]) // [R8]
    else $error("ready event lost");

  a_three_wire: assert property (s_wr(`SCRB_OFS_IFSETUP) |=> // [R9]
      threeWireSerial == $past(regWrData[0])) else $error("wire mode wrong");

  a_ifsetup_store: assert property (s_wr(`SCRB_OFS_IFSETUP) |=> // [R10] [R11]
      st_q.ifSetup[2:1] == $past(regWrData[2:1])) else $error("watchdog setup lost");

  a_wdt_off: assert property (!st_q.ifSetup[1] ##1 !st_q.ifSetup[1] |-> !wdtTimeout) // [R10]
    else $error("watchdog fired while off");

  a_power_enables: assert property (s_wr(`SCRB_OFS_PWRCTL) |=> // [R12] [R13]
      pressEnable == $past(regWrData[0]) && tempEnable == $past(regWrData[1]))
    else $error("channel enables wrong");

  a_forced_start: assert property (s_wr(`SCRB_OFS_PWRCTL) ##0 regWrData[5:4] == 2'h1 // [R14]
      |=> measStart && powerMode == SCRB_FORCED) else $error("forced start missing");

  a_forced_done: assert property (clkEn && measDone && powerMode == SCRB_FORCED // [R14]
      && !regWrEn |=> powerMode == SCRB_SLEEP) else $error("forced mode stuck");

  a_osr_store: assert property (s_wr(`SCRB_OFS_OSR) |=> // [R15]
      {thermalOversample, pressOversample} == $past(regWrData[5:0]))
    else $error("oversampling wrong");

  a_odr_saturate: assert property (s_wr(`SCRB_OFS_ODR) // [R16]
      ##0 regWrData[4:0] > `SCRB_ODR_MAX |=> odrExponent == `SCRB_ODR_MAX)
    else $error("rate not saturated");

  a_odr_plain: assert property (s_wr(`SCRB_OFS_ODR) // [R16]
      ##0 regWrData[4:0] <= `SCRB_ODR_MAX |=> odrExponent == $past(regWrData[4:0]))
    else $error("rate not stored");

  a_sleep_quiet: assert property (powerMode == SCRB_SLEEP && !regWrEn |=> !measStart) // [R14]
    else $error("measurement in sleep");

  a_iir_bypass: assert property (iirBypass |-> iirCoef == 7'h00) // [R18]
    else $error("bypass with coefficient");

  a_iir_store: assert property (s_wr(`SCRB_OFS_IIR) |=> // [R18]
      iirBypass == ($past(regWrData[3:1]) == 3'h0)) else $error("bypass wrong");

  a_reserved_zero: assert property (clkEn && regRdEn && regAddr == `SCRB_OFS_IIR // [R19]
      |=> regRdData[7:4] == 4'h0 && regRdData[0] == 1'b0)
    else $error("reserved bits read set");

  a_rd_unmapped: assert property (clkEn && regRdEn && !regHit // [R19]
      |=> regRdData == `SCRB_RESET_BYTE) else $error("unmapped read set");
endmodule // scrb_config_bank

//--- core/scrb_interval_timer.sv
// Purpose: Free counter that pulses once every limit cycles while running
// Assumes: limit of at least two
// Notes:   restart or a stopped run clears the count
`timescale 1ns/1ps
module scrb_interval_timer #(
  parameter int WIDTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  input  wire logic             run,
  input  wire logic             restart,
  input  wire logic [WIDTH-1:0] limit,
  output logic                  expire
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             expire;
  } scrb_timer_s;

  scrb_timer_s st_q, st_d;

  if (WIDTH < 2) begin : g_bad_width
    $error("scrb_interval_timer: WIDTH too small");
  end

  always_comb begin
    st_d = st_q;
    st_d.expire = 1'b0;
    if (rst) begin
      st_d = '0;
    end else if (restart || !run) begin
      st_d.cnt = '0;
    end else if (st_q.cnt >= limit - WIDTH'(1)) begin
      st_d.cnt = '0;
      st_d.expire = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + WIDTH'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || clkEn) begin
      st_q <= st_d;
    end
  end

  assign expire = st_q.expire;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_expire_at_limit: assert property (clkEn && run && !restart && !expire
      && st_q.cnt == limit - WIDTH'(1) |=> expire) else $error("timer missed limit"); // [R11]
  a_expire_single: assert property (expire |-> st_q.cnt == '0)
    else $error("timer pulse without wrap"); // [R17]
endmodule // scrb_interval_timer

//--- core/scrb_irq_pin.sv
// Purpose: Interrupt pin driver with polarity and drive selection
// Assumes: irqActive is a logical level from same-clock logic
// Notes:   Open drain only ever pulls low
`timescale 1ns/1ps
module scrb_irq_pin (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic clkEn,
  input  wire logic irqActive,
  input  wire logic activeHigh,
  input  wire logic openDrain,
  output logic      irqPinOut,
  output logic      irqPinOe
);
  typedef struct packed {
    logic out;
    logic oe;
  } scrb_pin_s;

  scrb_pin_s st_q, st_d;
  logic      level;

  always_comb begin
    level = (irqActive == activeHigh);       // [R4]
    st_d = st_q;
    if (rst) begin
      st_d = '0;
    end else if (openDrain) begin
      st_d.out = 1'b0;                       // [R3]
      st_d.oe = !level;
    end else begin
      st_d.out = level;
      st_d.oe = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || clkEn) begin
      st_q <= st_d;
    end
  end

  assign irqPinOut = st_q.out;
  assign irqPinOe = st_q.oe;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_od_never_high: assert property (clkEn && openDrain |=> !(irqPinOe && irqPinOut))
    else $error("open drain drove high"); // [R3]
  a_pin_polarity: assert property (clkEn && !openDrain |=>
      irqPinOe && irqPinOut == ($past(irqActive) == $past(activeHigh)))
    else $error("interrupt level wrong"); // [R4]
endmodule // scrb_irq_pin

//--- core/scrb_params.svh
// Purpose: Offsets, masks, resets and timing of the sensor configuration bank
// Assumes: Byte-wide register port, 40 MHz sys_clk
// Notes:   Definitions only
`ifndef SCRB_PARAMS_SVH
`define SCRB_PARAMS_SVH

`define SCRB_OFS_FIFO2      8'h18
`define SCRB_OFS_INTCTL     8'h19
`define SCRB_OFS_IFSETUP    8'h1a
`define SCRB_OFS_PWRCTL     8'h1b
`define SCRB_OFS_OSR        8'h1c
`define SCRB_OFS_ODR        8'h1d
`define SCRB_OFS_IIR        8'h1f

`define SCRB_MASK_FIFO2     8'h1f
`define SCRB_MASK_INTCTL    8'h5f
`define SCRB_MASK_IFSETUP   8'h07
`define SCRB_MASK_PWRCTL    8'h33
`define SCRB_MASK_OSR       8'h3f
`define SCRB_MASK_ODR       8'h1f
`define SCRB_MASK_IIR       8'h0e
`define SCRB_RESET_BYTE     8'h00

`define SCRB_ODR_MAX        5'h11
`define SCRB_CLK_PERIOD_NS  25
`define SCRB_WDT_SHORT_NS   1250000
`define SCRB_WDT_LONG_NS    40000000
`define SCRB_BASE_PERIOD_NS 5000000

`endif

//--- core/scrb_pkg.sv
// Purpose: Types shared by the sensor configuration bank
// Assumes: Nothing
// Notes:   Mode decode follows the two-bit power mode field
package scrb_pkg;

  typedef enum logic [1:0] {
    SCRB_SLEEP,
    SCRB_FORCED,
    SCRB_NORMAL
  } scrb_mode_e;

  function automatic scrb_mode_e scrb_decode_mode(input logic [1:0] code);
    scrb_mode_e m;
    case (code)
      2'h0:    m = SCRB_SLEEP;
      2'h3:    m = SCRB_NORMAL;
      default: m = SCRB_FORCED;
    endcase
    return m;
  endfunction

endpackage

//--- tb/scrb_config_bank_test.sv
// Purpose: Self-checking bench for the sensor configuration bank
// Assumes: Short timer parameters stand in for the long counts
// Notes:   Register port, events, timers and pin driven from the bench
`timescale 1ns/1ps
`include "scrb_params.svh"
module scrb_config_bank_test
  import scrb_pkg::*;
;
  localparam int BASE   = 8;
  localparam int WSHORT = 4;
  localparam int WLONG  = 16;

  logic       sysClk      = 1'b0;
  logic       rst         = 1'b1;
  logic [7:0] regAddr     = 8'h00;
  logic       regWrEn     = 1'b0;
  logic [7:0] regWrData   = 8'h00;
  logic       regRdEn     = 1'b0;
  logic [2:0] evtVec      = 3'h0;
  logic [2:0] intFlagsClr = 3'h0;
  logic       i2cBusy     = 1'b0;
  logic       measDone    = 1'b0;
  logic [7:0] regRdData;
  logic       regHit;
  logic [2:0] intFlags;
  logic       irqPinOut;
  logic       irqPinOe;
  logic [2:0] fifoDecimation;
  logic       fifoFiltered;
  logic       fifoSampleTake;
  logic       threeWireSerial;
  logic       wdtTimeout;
  logic       pressEnable;
  logic       tempEnable;
  scrb_mode_e powerMode;
  logic       measStart;
  logic [2:0] pressOversample;
  logic [2:0] thermalOversample;
  logic [4:0] odrExponent;
  logic       iirBypass;
  logic [6:0] iirCoef;
  int         nErrors     = 0;
  int         checked     = 0;
  int         cyc         = 0;
  int         nStart      = 0;
  int         nTake       = 0;
  int         gapStart    = 0;
  int         lastStart   = 0;
  int         n0;
  logic [7:0] offs [7]    = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1f};
  logic [7:0] fullExp [7] = '{8'h1f, 8'h5f, 8'h07, 8'h33, 8'h3f, 8'h11, 8'h0e};
  logic [7:0] enBits [3]  = '{8'h08, 8'h10, 8'h40};
  logic [7:0] odrIn [4]   = '{8'h10, 8'h11, 8'h12, 8'hff};
  logic [7:0] odrExp [4]  = '{8'h10, 8'h11, 8'h11, 8'h11};
  wire        pinLevel    = irqPinOe ? irqPinOut : 1'b1;

  always #12.5 sysClk = ~sysClk;

  scrb_config_bank #(
    .BASE_CYCLES     (BASE),
    .WDT_SHORT_CYCLES(WSHORT),
    .WDT_LONG_CYCLES (WLONG)
  ) u_dut (
    .sys_clk(sysClk), .rst(rst), .clkEn(1'b1), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .regHit(regHit),
    .fifoWatermarkEvt(evtVec[0]), .fifoFullEvt(evtVec[1]), .dataReadyEvt(evtVec[2]),
    .intFlagsClr(intFlagsClr), .intFlags(intFlags), .irqPinOut(irqPinOut),
    .irqPinOe(irqPinOe), .fifoDecimation(fifoDecimation), .fifoFiltered(fifoFiltered),
    .fifoSampleTake(fifoSampleTake), .threeWireSerial(threeWireSerial),
    .nvmWdtEn(1'b1), .nvmWdtSel(1'b0), .i2cBusy(i2cBusy), .i2cActivity(1'b0),
    .wdtTimeout(wdtTimeout), .pressEnable(pressEnable), .tempEnable(tempEnable),
    .powerMode(powerMode), .measDone(measDone), .measStart(measStart),
    .pressOversample(pressOversample), .thermalOversample(thermalOversample),
    .odrExponent(odrExponent), .iirBypass(iirBypass), .iirCoef(iirCoef)
  );

  // Pulse counters and spacing of measurement starts
  always @(posedge sysClk) begin
    cyc <= cyc + 1;
    if (measStart === 1'b1) begin
      nStart <= nStart + 1;
      gapStart <= cyc - lastStart;
      lastStart <= cyc;
    end
    if (fifoSampleTake === 1'b1) begin
      nTake <= nTake + 1;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      nErrors++;
      $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sysClk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sysClk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sysClk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sysClk);
    regRdEn <= 1'b0;
    #1;
    chk(regRdData, exp, "read");
  endtask

  task automatic pulse(input logic [2:0] ev, input logic [2:0] clr);
    @(posedge sysClk);
    evtVec <= ev;
    intFlagsClr <= clr;
    @(posedge sysClk);
    evtVec <= 3'h0;
    intFlagsClr <= 3'h0;
    #1;
  endtask

  task automatic tick();
    @(posedge sysClk);
    #1;
  endtask

  task automatic irqCase(input logic [7:0] cfg, input logic [1:0] idle, input logic [1:0] act);
    wr(`SCRB_OFS_INTCTL, cfg);
    tick();
    chk({6'h0, irqPinOe, pinLevel}, {6'h0, idle}, "idle pin");
    pulse(3'h2, 3'h0);
    chk({5'h0, intFlags}, 8'h02, "flag set");
    tick();
    chk({6'h0, irqPinOe, pinLevel}, {6'h0, act}, "active pin");
    pulse(3'h0, 3'h2);
    tick();
    chk({6'h0, irqPinOe, pinLevel}, {6'h0, idle}, "released pin");
  endtask

  task automatic wdtCase(input logic [7:0] cfg, input int lim);
    int  t0;
    int  gap;
    logic seen;
    seen = 1'b0;
    gap = 0;
    wr(`SCRB_OFS_IFSETUP, cfg);
    @(posedge sysClk);
    i2cBusy <= 1'b1;
    #1;
    t0 = cyc;
    for (int i = 0; i < 60 && !seen; i++) begin
      tick();
      if (wdtTimeout === 1'b1) begin
        seen = 1'b1;
        gap = cyc - t0;
      end
    end
    @(posedge sysClk);
    i2cBusy <= 1'b0;
    if (lim == 0) begin
      chk({7'h0, seen}, 8'h00, "no timeout");
    end else begin
      chk({7'h0, seen && gap >= lim && gap <= lim + 3}, 8'h01, "timeout span");
    end
  endtask

  task automatic done(input string name);
    $display("Test %s finished", name);
  endtask

  task automatic conclude();
    $display("Counts: %0d checks, %0d mismatches", checked, nErrors);
    if (nErrors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sysClk);
    nErrors++;
    $display("BAD %0t run took too long", $time);
    conclude();
  end

  initial begin
    repeat (8) @(posedge sysClk);
    rst <= 1'b0;
    tick();
    chk({6'h0, irqPinOe, pinLevel}, 8'h03, "pin after reset");
    chk({5'h0, intFlags}, 8'h00, "flags after reset");
    chk(8'(powerMode), 8'(SCRB_SLEEP), "mode after reset");
    for (int i = 0; i < 7; i++) rd(offs[i], (i == 2) ? 8'h02 : 8'h00);
    chk({7'h0, regHit}, 8'h01, "mapped hit");
    done("reset");
    for (int i = 0; i < 7; i++) wr(offs[i], 8'hff);
    for (int i = 0; i < 7; i++) rd(offs[i], fullExp[i]);
    chk({1'b0, fifoDecimation, fifoFiltered, threeWireSerial, pressEnable, tempEnable},
        8'h77, "decoded outputs");
    chk({2'b0, thermalOversample, pressOversample}, 8'h3f, "oversampling");
    rd(8'h1e, 8'h00);
    chk({7'h0, regHit}, 8'h00, "unmapped hit");
    rd(8'h17, 8'h00);
    rd(8'h20, 8'h00);
    done("registers");
    for (int c = 0; c < 4; c++) begin
      wr(`SCRB_OFS_FIFO2, 8'(c << 3) | 8'h05);
      #1;
      chk({4'h0, fifoDecimation, fifoFiltered}, {4'h0, 3'h5, c == 1}, "source");
    end
    for (int c = 0; c < 8; c++) begin
      wr(`SCRB_OFS_IIR, 8'(c << 1));
      #1;
      chk(8'(iirCoef), 8'((1 << c) - 1), "coefficient");
      chk({7'h0, iirBypass}, 8'(c == 0), "bypass");
    end
    for (int c = 0; c < 6; c++) begin
      wr(`SCRB_OFS_OSR, 8'(c | ((5 - c) << 3)));
      #1;
      chk({2'b0, thermalOversample, pressOversample}, 8'(c | ((5 - c) << 3)), "osr");
    end
    for (int i = 0; i < 4; i++) begin
      wr(`SCRB_OFS_ODR, odrIn[i]);
      rd(`SCRB_OFS_ODR, odrExp[i]);
      chk({3'h0, odrExponent}, odrExp[i], "rate exponent");
    end
    done("decode");
    irqCase(8'h5c, 2'b11, 2'b10);
    irqCase(8'h5e, 2'b10, 2'b11);
    irqCase(8'h5d, 2'b01, 2'b10);
    irqCase(8'h5f, 2'b10, 2'b01);
    for (int b = 0; b < 3; b++) begin
      wr(`SCRB_OFS_INTCTL, 8'h04 | enBits[b]);
      for (int e = 0; e < 3; e++) begin
        pulse(3'h1 << e, 3'h0);
        repeat (2) tick();
        chk({5'h0, intFlags}, (e == b) ? 8'h01 << b : 8'h00, "latched flag");
        pulse(3'h0, 3'h7);
      end
    end
    pulse(3'h4, 3'h4);
    chk({5'h0, intFlags}, 8'h04, "set beats clear");
    wr(`SCRB_OFS_INTCTL, 8'h08);
    pulse(3'h1, 3'h0);
    chk({5'h0, intFlags}, 8'h01, "unlatched flag");
    tick();
    chk({5'h0, intFlags}, 8'h00, "unlatched drop");
    done("interrupts");
    wr(`SCRB_OFS_FIFO2, 8'h02);
    n0 = nTake;
    @(posedge sysClk);
    evtVec <= 3'h4;
    repeat (8) @(posedge sysClk);
    evtVec <= 3'h0;
    repeat (3) tick();
    chk(8'(nTake - n0), 8'h02, "decimation count");
    done("decimation");
    wr(`SCRB_OFS_PWRCTL, 8'h00);
    wr(`SCRB_OFS_ODR, 8'h01);
    wr(`SCRB_OFS_PWRCTL, 8'h30);
    n0 = nStart;
    for (int i = 0; i < 200 && nStart < n0 + 3; i++) tick();
    chk(8'(gapStart), 8'(BASE << 1), "normal period");
    wr(`SCRB_OFS_PWRCTL, 8'h00);
    repeat (3) tick();
    for (int c = 1; c < 3; c++) begin
      n0 = nStart;
      wr(`SCRB_OFS_PWRCTL, 8'(c << 4) | 8'h03);
      #1;
      chk(8'(powerMode), 8'(SCRB_FORCED), "forced mode");
      repeat (4) tick();
      chk(8'(nStart - n0), 8'h01, "single start");
      @(posedge sysClk);
      measDone <= 1'b1;
      @(posedge sysClk);
      measDone <= 1'b0;
      rd(`SCRB_OFS_PWRCTL, 8'h03);
      chk(8'(powerMode), 8'(SCRB_SLEEP), "back to sleep");
    end
    done("measurement");
    wdtCase(8'h02, WSHORT);
    wdtCase(8'h06, WLONG);
    wdtCase(8'h04, 0);
    done("watchdog");
    conclude();
  end
endmodule // scrb_config_bank_test
